/* rtl/mrr_pkg.sv */
/*
 * Package for the mains reconnection release block: timing and width constants.
 * Assumes a 100 MHz system clock; all users reference names with the package scope.
 */
`default_nettype none
package mrr_pkg;
    // System clock period in nanoseconds.
    localparam int unsigned CLK_PERIOD_NS     = 10;
    // Number of decoupling trigger inputs per instance.
    localparam int unsigned NUM_DECOUPLE      = 6;
    // Default settle delay in milliseconds.
    localparam int unsigned SETTLE_DEFAULT_MS = 20;
    // Default settle delay in clock cycles, derived from the time and the rate.
    localparam int unsigned SETTLE_DEFAULT_CYC = SETTLE_DEFAULT_MS * 1000000 / CLK_PERIOD_NS;
    // Width of the settle counter and of the settle delay ports.
    localparam int unsigned SETTLE_W          = 32;
    // Number of independent reconnection instances.
    localparam int unsigned NUM_INST          = 2;
    // Evaluation state machine.
    typedef enum logic [1:0] {
        MRR_IDLE,
        MRR_EVAL,
        MRR_RELEASE
    } mrr_state_t;
endpackage
`default_nettype wire

/* rtl/mrr_top.sv */
/*
 * Mains reconnection release logic: two independent instances, each with a
 * trigger stage, an evaluation phase with settle timer, and a release output.
 * Assumes breaker, trip and limit-check inputs arrive asynchronously from pins
 * or other logic; every such input is double-synchronised before use.
 * Configuration inputs are quasi-static and are read directly.
 */
`default_nettype none
module mrr_top #(
    parameter int unsigned NI = mrr_pkg::NUM_INST,
    parameter int unsigned ND = mrr_pkg::NUM_DECOUPLE
) (
    input  wire logic                              clk_i,
    input  wire logic                              rst_n_i,
    input  wire logic [NI-1:0]                     enable_i,
    input  wire logic [NI-1:0]                     vt_sup_en_i,
    input  wire logic [NI-1:0]                     brk_assigned_i,
    input  wire logic [NI*ND-1:0]                  dec_assigned_i,
    input  wire logic [NI-1:0]                     use_meas_i,
    input  wire logic [NI-1:0]                     use_ext_i,
    input  wire logic [NI*mrr_pkg::SETTLE_W-1:0]   settle_cyc_i,
    input  wire logic [NI-1:0]                     block_i,
    input  wire logic [NI-1:0]                     vt_fuse_fail_in,
    input  wire logic [NI-1:0]                     external_block_in,
    input  wire logic [NI-1:0]                     brk_closed_i,
    input  wire logic [NI*ND-1:0]                  decouple_i,
    input  wire logic [NI-1:0]                     volt_in_lim_i,
    input  wire logic [NI-1:0]                     freq_in_lim_i,
    input  wire logic [NI-1:0]                     ext_voltage_ok_in,
    output logic      [NI-1:0]                     eval_o,
    output logic      [NI-1:0]                     release_o
);
    // One reconnection instance per loop pass, each fully independent.
    for (genvar g = 0; g < NI; g++) begin : g_inst
        mrr_inst #(
            .ND (ND)
        ) u_inst (
            .clk_i             (clk_i),
            .rst_n_i           (rst_n_i),
            .enable_i          (enable_i[g]),
            .vt_sup_en_i       (vt_sup_en_i[g]),
            .brk_assigned_i    (brk_assigned_i[g]),
            .dec_assigned_i    (dec_assigned_i[g*ND +: ND]),
            .use_meas_i        (use_meas_i[g]),
            .use_ext_i         (use_ext_i[g]),
            .settle_cyc_i      (settle_cyc_i[g*mrr_pkg::SETTLE_W +: mrr_pkg::SETTLE_W]),
            .block_i           (block_i[g]),
            .vt_fuse_fail_in   (vt_fuse_fail_in[g]),
            .external_block_in (external_block_in[g]),
            .brk_closed_i      (brk_closed_i[g]),
            .decouple_i        (decouple_i[g*ND +: ND]),
            .volt_in_lim_i     (volt_in_lim_i[g]),
            .freq_in_lim_i     (freq_in_lim_i[g]),
            .ext_voltage_ok_in (ext_voltage_ok_in[g]),
            .eval_o            (eval_o[g]),
            .release_o         (release_o[g])
        );
    end
endmodule

module mrr_inst #(
    parameter int unsigned ND = mrr_pkg::NUM_DECOUPLE
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_n_i,
    input  wire logic                          enable_i,
    input  wire logic                          vt_sup_en_i,
    input  wire logic                          brk_assigned_i,
    input  wire logic [ND-1:0]                 dec_assigned_i,
    input  wire logic                          use_meas_i,
    input  wire logic                          use_ext_i,
    input  wire logic [mrr_pkg::SETTLE_W-1:0]  settle_cyc_i,
    input  wire logic                          block_i,
    input  wire logic                          vt_fuse_fail_in,
    input  wire logic                          external_block_in,
    input  wire logic                          brk_closed_i,
    input  wire logic [ND-1:0]                 decouple_i,
    input  wire logic                          volt_in_lim_i,
    input  wire logic                          freq_in_lim_i,
    input  wire logic                          ext_voltage_ok_in,
    output logic                               eval_o,
    output logic                               release_o
);
    // Width of the synchronised bundle: block, fuse, ext block, breaker, volt,
    // freq, external ok, then decoupling inputs.
    localparam int unsigned SW = ND + 7;

    logic [SW-1:0]              sync1_ff;   // First synchroniser stage only.
    logic [SW-1:0]              sync2_ff;   // Second stage, safe to read.
    logic                       brk_d_ff;   // Breaker state one cycle ago.
    logic                       ok_d_ff;    // Limit conditions (lim_ok) one cycle ago.
    logic                       extok_d_ff; // External ok one cycle ago.
    logic [ND-1:0]              dec_d_ff;   // Decoupling inputs one cycle ago.
    logic [mrr_pkg::SETTLE_W-1:0] cnt_ff;   // Settle timer.
    logic [mrr_pkg::SETTLE_W-1:0] nxt_cnt;
    mrr_pkg::mrr_state_t        state_ff;
    mrr_pkg::mrr_state_t        nxt_state;
    logic                       eval_ff;    // Evaluating flag, held in a flip-flop.
    logic                       rel_ff;     // Release level, held in a flip-flop.

    // Two flip-flops before any logic sees a pin-side level.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {decouple_i, ext_voltage_ok_in, freq_in_lim_i, volt_in_lim_i,
                         brk_closed_i, external_block_in, vt_fuse_fail_in, block_i};
            sync2_ff <= sync1_ff;
        end
    end

    // Named views of the synchronised inputs.
    wire logic          s_block  = sync2_ff[0];
    wire logic          s_fuse   = sync2_ff[1];
    wire logic          s_exblk  = sync2_ff[2];
    wire logic          s_brk    = sync2_ff[3];
    wire logic          s_volt   = sync2_ff[4];
    wire logic          s_freq   = sync2_ff[5];
    wire logic          s_extok  = sync2_ff[6];
    wire logic [ND-1:0] s_dec    = sync2_ff[SW-1:7];

    // Only assigned decoupling inputs take part.
    wire logic [ND-1:0] dec_act  = s_dec & dec_assigned_i;
    wire logic          dec_any  = |dec_act;
    wire logic          dec_rise = |(dec_act & ~dec_d_ff);
    wire logic          dec_mode = |dec_assigned_i;
    wire logic          brk_fall = brk_assigned_i & brk_d_ff & ~s_brk;
    wire logic          brk_rise = brk_assigned_i & ~brk_d_ff & s_brk;

    // Whole function is blocked by deactivation, blocks or configured fuse fail.
    wire logic blocked = ~enable_i | s_block | s_exblk
                         | (vt_sup_en_i & s_fuse);

    // Voltage validity from measurement and/or external signal.
    wire logic volt_ok = (~use_meas_i | s_volt) & (~use_ext_i | s_extok);
    // Limit conditions without the decoupling term.
    wire logic lim_ok  = volt_ok & s_freq;
    // Full release condition set during evaluation.
    wire logic cond_ok = ~dec_any & lim_ok;

    // Out-of-range or external-ok falling edge as a trigger source.
    wire logic lim_fall = (ok_d_ff & ~lim_ok) | (use_ext_i & extok_d_ff & ~s_extok);

    // Trigger by assignment mode.
    wire logic trig = (brk_assigned_i & dec_mode) ? (brk_fall & dec_any)
                    : brk_assigned_i              ? brk_fall
                    : dec_mode                    ? dec_rise
                    :                               lim_fall;

    // Reasons to drop a standing release.
    wire logic drop = ~lim_ok | brk_rise | (dec_mode & dec_rise)
                    | (dec_mode & brk_assigned_i & dec_any);

    wire logic timer_done = (cnt_ff >= settle_cyc_i);

    // Next state and settle counter.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        if (blocked) begin
            // Blocked: all activity suppressed and the timer cleared.
            nxt_state = mrr_pkg::MRR_IDLE;
            nxt_cnt   = '0;
        end else begin
            unique case (state_ff)
                mrr_pkg::MRR_IDLE: begin
                    // Wait for the trigger of the configured mode.
                    nxt_cnt = '0;
                    if (trig) begin
                        nxt_state = mrr_pkg::MRR_EVAL;
                    end
                end
                mrr_pkg::MRR_EVAL: begin
                    // Run timer while all conditions hold; any failure restarts it.
                    if (!cond_ok) begin
                        nxt_cnt = '0;
                    end else if (timer_done) begin
                        nxt_state = mrr_pkg::MRR_RELEASE;
                        nxt_cnt   = '0;
                    end else begin
                        nxt_cnt = cnt_ff + 1'b1;
                    end
                end
                mrr_pkg::MRR_RELEASE: begin
                    // A dropping event ends release; a trigger in the same cycle re-enters evaluation.
                    nxt_cnt = '0;
                    if (drop) begin
                        nxt_state = trig ? mrr_pkg::MRR_EVAL : mrr_pkg::MRR_IDLE;
                    end
                end
                default: begin
                    nxt_state = mrr_pkg::MRR_IDLE;
                end
            endcase
        end
    end

    // Output levels decoded from the next state, so that both flags leave flip-flops
    // and still change on the same edge as the state register.
    wire logic nxt_eval = (nxt_state == mrr_pkg::MRR_EVAL);
    wire logic nxt_rel  = (nxt_state == mrr_pkg::MRR_RELEASE);

    // State, edge history, counter and output registers.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff   <= mrr_pkg::MRR_IDLE;
            cnt_ff     <= '0;
            brk_d_ff   <= 1'b0;
            ok_d_ff    <= 1'b0;
            extok_d_ff <= 1'b0;
            dec_d_ff   <= '0;
            eval_ff    <= 1'b0;
            rel_ff     <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            brk_d_ff   <= s_brk;
            ok_d_ff    <= lim_ok;
            extok_d_ff <= s_extok;
            dec_d_ff   <= dec_act;
            eval_ff    <= nxt_eval;
            rel_ff     <= nxt_rel;
        end
    end

    // Outputs straight from their registers; the flag falls as release rises.
    assign eval_o    = eval_ff;
    assign release_o = rel_ff;

    AST_BLOCK_NO_OUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        blocked |=> !release_o && !eval_o)
        else $error("Output active one cycle after block.");
    AST_FUSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (vt_sup_en_i && s_fuse) |=> !release_o)
        else $error("Release with fuse fail.");
    AST_EXT_BLOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_exblk |=> !release_o)
        else $error("Release with external block.");
    AST_EVAL_TO_REL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(release_o) |-> $past(eval_o) && !eval_o)
        else $error("Release not preceded by evaluation.");
    AST_SETTLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (eval_o && !blocked && cond_ok && timer_done) |=> release_o)
        else $error("Release missing after timer.");
    AST_COND_REL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(release_o) |-> $past(cond_ok))
        else $error("Release with conditions unmet.");
    AST_RESTART: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (eval_o && !cond_ok && !blocked) |=> cnt_ff == '0)
        else $error("Timer not restarted.");
    AST_COMBINED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (brk_assigned_i && dec_mode && !eval_o && !release_o && $rose(eval_o) == 1'b0
         && !(brk_fall && dec_any)) |=> !eval_o)
        else $error("Combined mode entered without trigger.");
    AST_DROP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (release_o && !lim_ok) |=> !release_o)
        else $error("Release held after limit failure.");
    AST_NOTRIG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!brk_assigned_i && !dec_mode && !blocked && !eval_o && !release_o && lim_fall)
        |=> eval_o)
        else $error("No-assignment trigger missed.");
endmodule
`default_nettype wire

/* test/mrr_grid_model.sv */
/* Far-side model: breaker position and decoupling trip lines of both
   reconnection instances. Assumes one bench process calls its tasks. */
`default_nettype none
module mrr_grid_model #(
    parameter int unsigned NI = 2,
    parameter int unsigned ND = 6
) (
    input  wire logic             clk_i,
    output var  logic [NI-1:0]    brk_closed_o,
    output var  logic [NI*ND-1:0] decouple_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Breakers start open, so the first close is a real edge for the block.
    initial begin
        brk_closed_o = '0;
        decouple_o   = '0;
    end
    // Every change lands just after a rising edge.
    task automatic set_brk(input int g, input logic v);
        @(posedge clk_i);
        #1 brk_closed_o[g] = v;
    endtask
    // One trip line of one instance is set or cleared.
    task automatic set_trip(input int g, input int k, input logic v);
        @(posedge clk_i);
        #1 decouple_o[g*ND+k] = v;
    endtask
    // The trip leads the breaker opening and is held until the block has seen both.
    task automatic trip_open(input int g, input int k);
        set_trip(g, k, 1'b1);
        set_brk(g, 1'b0);
        repeat (4) @(posedge clk_i);
        set_trip(g, k, 1'b0);
    endtask
endmodule
`default_nettype wire

/* test/mrr_top_tb.sv */
/* Self-checking bench for mrr_top: drives configuration and limit flags,
   while mrr_grid_model drives the breaker and trip lines. Assumes 10 ns clock. */
`default_nettype none
module mrr_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int S = 10; // Short settle delay keeps the run brief.
    logic        clk_i;
    logic        rst_n_i;
    logic [1:0]  en, vts, basg, umeas, uext, blk, fuse, xblk, volt, freq, extok;
    logic [1:0]  brk, evl, rls;
    logic [11:0] dasg, dec;
    logic [63:0] settle;
    int          mismatches, samples_checked, n, m;
    // Free-running clock at 100 MHz.
    initial clk_i = 1'b0;
    always #5 clk_i = ~clk_i;
    mrr_top mrr_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(en), .vt_sup_en_i(vts),
        .brk_assigned_i(basg), .dec_assigned_i(dasg), .use_meas_i(umeas), .use_ext_i(uext),
        .settle_cyc_i(settle), .block_i(blk), .vt_fuse_fail_in(fuse),
        .external_block_in(xblk), .brk_closed_i(brk), .decouple_i(dec),
        .volt_in_lim_i(volt), .freq_in_lim_i(freq), .ext_voltage_ok_in(extok),
        .eval_o(evl), .release_o(rls));
    mrr_grid_model mdl (.clk_i(clk_i), .brk_closed_o(brk), .decouple_o(dec));
    // Inputs move 1 ns after an edge, so no race with the sampling edge.
    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask
    // Counts a comparison and reports a difference at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Bounded wait for a level on eval (r=0) or release (r=1); c counts edges.
    task automatic wait_for(input int g, input bit r, input logic v, input int b, output int c);
        c = 0;
        while ((r ? rls[g] : evl[g]) !== v) begin
            if (c == b) begin
                mismatches++;
                print_verdict();
            end
            tick(1);
            c++;
        end
    endtask
    initial begin
        rst_n_i = 1'b0;
        {en, vts, basg, umeas, uext} = 10'h3ff;
        {blk, fuse, xblk} = 6'h00;
        // A high frequency flag means inside limits kept within 4 Hz of nominal.
        {volt, freq, extok} = 6'h3f;
        dasg = 12'h03f; // Instance 0 combined, instance 1 breaker only.
        // The settle delay of S cycles for both instances is
        // the scaled stand-in for one mains period.
        settle = {2{32'(S)}};
        tick(4);
        rst_n_i = 1'b1;
        mdl.set_brk(0, 1'b1);
        mdl.set_brk(1, 1'b1);
        tick(6);
        // Breaker-only instance: trigger, settle and drop timing.
        mdl.set_brk(1, 1'b0);
        wait_for(1, 0, 1'b1, 8, n);
        check(n, 3);
        wait_for(1, 1, 1'b1, 40, m);
        check(n + m, S + 4);
        check({evl, rls[0]}, 3'h0);
        mdl.set_brk(1, 1'b1);
        wait_for(1, 1, 1'b0, 8, n);
        check(n, 3);
        // A limit glitch mid-count must restart the settle timer.
        mdl.set_brk(1, 1'b0);
        wait_for(1, 0, 1'b1, 8, n);
        tick(2);
        volt[1] = 1'b0;
        tick(2);
        volt[1] = 1'b1;
        wait_for(1, 1, 1'b1, 40, n);
        check(n >= S + 3, 1'b1);
        // Each block source in turn: disable, block, fuse fail, external block.
        for (int b = 0; b < 4; b++) begin
            {xblk[1], fuse[1], blk[1], en[1]} = (4'h1 << b) ^ 4'h1;
            wait_for(1, 1, 1'b0, 4, n);
            tick(1);
            check({evl[1], rls[1]}, 2'h0);
            {xblk[1], fuse[1], blk[1], en[1]} = 4'h1;
            mdl.set_brk(1, 1'b1);
            tick(8);
            check(rls[1], 1'b0);
            mdl.set_brk(1, 1'b0);
            wait_for(1, 1, 1'b1, 40, n);
        end
        // Fuse fail is ignored while supervision is off.
        vts[1] = 1'b0;
        fuse[1] = 1'b1;
        tick(8);
        check(rls[1], 1'b1);
        fuse[1] = 1'b0;
        tick(4);
        vts[1] = 1'b1;
        // Combined mode over all six trip lines; close or new trip drops release.
        for (int k = 0; k < 6; k++) begin
            mdl.trip_open(0, k);
            wait_for(0, 0, 1'b1, 4, n);
            wait_for(0, 1, 1'b1, 40, n);
            check({evl[0], rls[1]}, 2'h1);
            if (k[0]) begin
                mdl.set_trip(0, k, 1'b1);
            end else begin
                mdl.set_brk(0, 1'b1);
            end
            wait_for(0, 1, 1'b0, 8, n);
            check(n, 3);
            mdl.set_trip(0, k, 1'b0);
            mdl.set_brk(0, 1'b1);
            tick(4);
        end
        // Breaker opening without a trip must not start evaluation.
        mdl.set_brk(0, 1'b0);
        tick(8);
        check(evl[0], 1'b0);
        mdl.set_brk(0, 1'b1);
        // Decoupling-only mode.
        basg[0] = 1'b0;
        mdl.set_trip(0, 5, 1'b1);
        wait_for(0, 0, 1'b1, 8, n);
        check(n, 3);
        mdl.set_trip(0, 5, 1'b0);
        wait_for(0, 1, 1'b1, 40, n);
        mdl.set_trip(0, 0, 1'b1);
        wait_for(0, 1, 1'b0, 8, n);
        check(n, 3);
        tick(S + 6);
        check(rls[0], 1'b0);
        mdl.set_trip(0, 0, 1'b0);
        wait_for(0, 1, 1'b1, 40, n);
        // No assignments: each limit or external-ok fall triggers a new evaluation.
        dasg[5:0] = 6'h00;
        for (int c = 0; c < 3; c++) begin
            {extok[0], freq[0], volt[0]} = 3'h7 ^ (3'h1 << c);
            wait_for(0, 0, 1'b1, 8, n);
            check({rls[0], n[7:0]}, 9'h003);
            {extok[0], freq[0], volt[0]} = 3'h7;
            wait_for(0, 1, 1'b1, 40, n);
        end
        // With measurement unused a voltage flag fall is ignored.
        umeas[0] = 1'b0;
        volt[0] = 1'b0;
        tick(8);
        check({evl[0], rls[0]}, 2'h1);
        // With the external signal unused its fall is ignored as well.
        volt[0] = 1'b1;
        tick(4);
        umeas[0] = 1'b1;
        uext[0] = 1'b0;
        extok[0] = 1'b0;
        tick(8);
        check({evl[0], rls[0]}, 2'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
